// file: src/mf_port_pkg.sv
// Shared constants, types and code helpers for the tone transceiver host port
package mf_port_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int RESET_HOLD_CYCLES = 5;
    localparam int SCLK_KHZ = 2048;
    localparam int FRAME_KHZ = 8;
    localparam int BITS_PER_FRAME = SCLK_KHZ / FRAME_KHZ;
    localparam int FRAME_HZ = FRAME_KHZ * 1000;
    localparam int TONE_MIN_MS = 30;
    localparam int KP_LONG_MS = 55;
    localparam int TONE_MIN_FRAMES = TONE_MIN_MS * FRAME_HZ / 1000;
    localparam int KP_LONG_FRAMES = KP_LONG_MS * FRAME_HZ / 1000;
    localparam int ALIVE_MAX_MS = 10;
    // Toggle four times per allowed window for margin
    localparam int ALIVE_HALF_CYCLES = CLK_KHZ * ALIVE_MAX_MS / 4;
    localparam int FRAME_CNT_W = 10;
    localparam int ACC_W = 16;
    localparam int ALIVE_W = 18;
    // ------------------------------------------------------------
    // Byte layout
    // ------------------------------------------------------------
    localparam int CMD_BIT = 7;
    localparam int SEL_BIT = 6;
    localparam int CLKSRC_BIT = 5;
    localparam int FORMAT_BIT = 4;
    localparam int LAW_BIT = 4;
    localparam int ENABLE_BIT = 3;
    localparam int KPLONG_BIT = 2;
    localparam int GATE_BIT = 1;
    localparam int ZERO_BIT = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Frequency flags, first frequency in bit 0
    localparam logic [5:0] TONE_KP = 6'h24;
    localparam logic [5:0] TONE_ST = 6'h30;
    localparam logic [5:0] TONE_ST1 = 6'h22;
    localparam logic [5:0] TONE_ST2 = 6'h28;
    localparam logic [5:0] TONE_ST3 = 6'h21;
    // Binary code to pair table, code zero means tone off
    localparam logic [5:0] PAIR_TABLE [16] = '{6'h00, 6'h03, 6'h05, 6'h06, 6'h09,
        6'h0A, 6'h0C, 6'h11, 6'h12, 6'h14, 6'h18, 6'h21, 6'h22, 6'h24, 6'h28, 6'h30};
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic clkExternal;  // codec_clock_source_select
        logic binary;       // tone_code_format_select
        logic aLaw;         // companding_law_select
        logic [1:0] enable;
        logic [1:0] longKp;
        logic [1:0] gated;
    } cfg_type;
    typedef struct packed {
        logic valid;
        logic channel;
        logic [5:0] flags;
    } tx_type;
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic sclk;
        logic [7:0] bitCnt;
        logic frame;
    } clkgen_state_type;
    typedef struct packed {
        logic [ALIVE_W-1:0] cnt;
        logic level;
    } alive_state_type;
    // Binary tone code to frequency flags
    function automatic logic [5:0] codeToFlags(input logic [3:0] code);
        return PAIR_TABLE[code];
    endfunction : codeToFlags
    // Frequency flags to binary tone code
    function automatic logic [3:0] flagsToCode(input logic [5:0] flags);
        logic [3:0] code;
        code = 4'h0;
        for (int k = 0; k < 16; k++)
        begin
            if (PAIR_TABLE[k] == flags)
                code = 4'(k);
        end
        return code;
    endfunction : flagsToCode
endpackage : mf_port_pkg

// file: src/codec_clock_gen.sv
// Internal serial bit clock and shared frame pulse generator
`timescale 1ns/1ps
module codec_clock_gen
    import mf_port_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    // Outputs
    output logic serialClock,
    output logic framePulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam logic [ACC_W-1:0] STEP = ACC_W'(2 * SCLK_KHZ);
    localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ);
    localparam logic [7:0] LAST_BIT = 8'(BITS_PER_FRAME - 1);
    clkgen_state_type s_r, s_nxt;
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Fractional accumulator: 25 MHz is no integer multiple of 2.048 MHz,
    // so edges jitter by one cycle but the mean rate is exact
    always_comb
    begin
        s_nxt = s_r;
        if (!run)
        begin
            s_nxt = '0;
        end
        else if (s_r.acc + STEP >= WRAP)
        begin
            s_nxt.acc = s_r.acc + STEP - WRAP;
            s_nxt.sclk = !s_r.sclk;
            // Rising edge counts bits and frames
            if (!s_r.sclk)
            begin
                s_nxt.bitCnt = (s_r.bitCnt == LAST_BIT) ? 8'h00 : s_r.bitCnt + 8'h01;
                s_nxt.frame = (s_r.bitCnt == LAST_BIT);
            end
        end
        else
        begin
            s_nxt.acc = s_r.acc + STEP;
        end
    end
    // Register
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign serialClock = s_r.sclk;
    assign framePulse = s_r.frame;
endmodule : codec_clock_gen

// file: src/alive_toggle.sv
// Alive indicator toggler
`timescale 1ns/1ps
module alive_toggle
    import mf_port_pkg::*;
#(
    parameter int HALF_CYCLES = ALIVE_HALF_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control and output
    input wire logic run,
    output logic aliveLevel
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    localparam logic [ALIVE_W-1:0] LAST = ALIVE_W'(HALF_CYCLES - 1);
    alive_state_type s_r, s_nxt;
    // Toggle only while running, so a stuck device shows no activity
    always_comb
    begin
        s_nxt = s_r;
        if (run)
        begin
            s_nxt.cnt = (s_r.cnt == LAST) ? '0 : s_r.cnt + 1'b1;
            if (s_r.cnt == LAST)
                s_nxt.level = !s_r.level;
        end
    end
    // Register
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign aliveLevel = s_r.level;
endmodule : alive_toggle

// file: src/mf_host_port.sv
// Host command port of the dual-channel tone transceiver
`timescale 1ns/1ps
module mf_host_port
    import mf_port_pkg::*;
#(
    parameter int ALIVE_HALF = ALIVE_HALF_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic device_reset_n,
    // Host latch port
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    output logic strobeForceOe,
    output logic output_latch_full_n,
    output logic input_latch_empty_flag,
    output logic alive_indicator,
    // Codec serial clocking
    output logic serialClockOut,
    output logic serialClockOe,
    output logic framePulse,
    output logic serialTxFloat,
    // Signal processing side
    output cfg_type cfg,
    output logic [1:0] detectActive,
    input wire logic [1:0] rawTick,
    input wire logic [1:0][5:0] rawFlags,
    output tx_type txCmd
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cfg_type cfg;
        logic [7:0] outByte;       // Output latch
        logic outFull;             // Unread byte in output latch
        logic [7:0] inByte;        // Input latch
        logic inPending;           // Written byte not yet consumed
        logic wrPrev;              // Last write strobe level
        logic rdPrev;              // Last read strobe level
        logic [2:0] rstCnt;        // Cycles reset pin held low
        logic inReset;             // Held in reset
        logic [1:0] window;        // Detection open after start tone
        logic [1:0][5:0] candFlags;
        logic [1:0][FRAME_CNT_W-1:0] candCnt;
        logic [1:0] pend;          // Detected tone awaiting latch
        logic [1:0][5:0] pendFlags;
        tx_type tx;
    } port_state_type;
    localparam logic [2:0] HOLD_LAST = 3'(RESET_HOLD_CYCLES - 1);
    localparam logic [FRAME_CNT_W-1:0] SHORT_N = FRAME_CNT_W'(TONE_MIN_FRAMES);
    localparam logic [FRAME_CNT_W-1:0] LONG_N = FRAME_CNT_W'(KP_LONG_FRAMES);
    // Reset image of the whole state
    localparam port_state_type RESET_STATE = '{
        cfg: '{clkExternal: 1'b1, default: '0},
        outByte: RESET_BYTE,
        outFull: 1'b1,
        wrPrev: 1'b1,
        rdPrev: 1'b1,
        default: '0
    };
    port_state_type s_r, s_nxt;
    logic frameInt;
    logic sclkInt;
    logic aliveLevel;
    // Stop-class tone test, shared by the per-channel loop
    function automatic logic isStop(input logic [5:0] f);
        return (f == TONE_ST) || (f == TONE_ST1) || (f == TONE_ST2) || (f == TONE_ST3);
    endfunction : isStop
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [FRAME_CNT_W-1:0] need;
        logic [5:0] txf;
        logic [5:0] lf;
        logic lch;
        logic fire;
        logic [1:0] fired;         // Channels qualifying a tone this cycle
        need = SHORT_N;
        fired = 2'b00;
        txf = '0;
        lf = '0;
        lch = 1'b0;
        fire = 1'b0;
        s_nxt = s_r;
        s_nxt.tx.valid = 1'b0;
        s_nxt.wrPrev = writeStrobeN;
        s_nxt.rdPrev = readStrobeN;
        // Write strobe: capture on rising edge, consume one cycle later
        // capture and consume
        if (!s_r.wrPrev && writeStrobeN)
        begin
            s_nxt.inByte = dataIn;
            s_nxt.inPending = 1'b1;
        end
        else if (s_r.inPending)
        begin
            s_nxt.inPending = 1'b0;
            if (s_r.inByte[CMD_BIT])
            begin
                if (s_r.cfg.binary)
                    txf = codeToFlags(s_r.inByte[3:0]);
                else
                    txf = s_r.inByte[5:0];
                if (s_r.cfg.enable[s_r.inByte[SEL_BIT]] &&
                    !(s_r.cfg.binary && s_r.inByte[5:4] != 2'b00))
                begin
                    s_nxt.tx.valid = 1'b1;
                    s_nxt.tx.channel = s_r.inByte[SEL_BIT];
                    s_nxt.tx.flags = txf;
                end
            end
            else if (!s_r.inByte[ZERO_BIT])
            begin
                if (!s_r.inByte[SEL_BIT])
                begin
                    s_nxt.cfg.clkExternal = s_r.inByte[CLKSRC_BIT];
                    s_nxt.cfg.binary = s_r.inByte[FORMAT_BIT];
                end
                else
                begin
                    s_nxt.cfg.aLaw = s_r.inByte[LAW_BIT];
                end
                s_nxt.cfg.enable[s_r.inByte[SEL_BIT]] = s_r.inByte[ENABLE_BIT];
                s_nxt.cfg.longKp[s_r.inByte[SEL_BIT]] = s_r.inByte[KPLONG_BIT];
                s_nxt.cfg.gated[s_r.inByte[SEL_BIT]] = s_r.inByte[GATE_BIT];
            end
        end
        // Per-channel tone qualification on each sample frame tick
        for (int i = 0; i < 2; i++)
        begin
            need = (s_r.candFlags[i] == TONE_KP && s_r.cfg.longKp[i]) ? LONG_N : SHORT_N;
            fire = 1'b0;
            if (!s_r.cfg.enable[i])
            begin
                s_nxt.candFlags[i] = '0;
                s_nxt.candCnt[i] = '0;
            end
            else if (rawTick[i])
            begin
                if (rawFlags[i] != s_r.candFlags[i])
                begin
                    s_nxt.candFlags[i] = rawFlags[i];
                    s_nxt.candCnt[i] = '0;
                end
                else if (s_r.candFlags[i] != '0 && s_r.candCnt[i] < need)
                begin
                    s_nxt.candCnt[i] = s_r.candCnt[i] + 1'b1;
                    fire = (s_r.candCnt[i] + 1'b1 == need);
                end
            end
            fired[i] = fire;
            if (fire)
            begin
                if (!s_r.cfg.gated[i] || s_r.window[i] ||
                    s_r.candFlags[i] == TONE_KP)
                begin
                    s_nxt.pend[i] = 1'b1;
                    s_nxt.pendFlags[i] = s_r.candFlags[i];
                end
                if (s_r.candFlags[i] == TONE_KP)
                    s_nxt.window[i] = 1'b1;
                else if (isStop(s_r.candFlags[i]))
                    s_nxt.window[i] = 1'b0;
            end
        end
        if (!readStrobeN)
            s_nxt.outFull = 1'b0;
        // Load only with strobe idle so read data never changes mid-read
        if (!s_r.outFull && readStrobeN && s_r.rdPrev && (s_r.pend != 2'b00))
        begin
            lch = !s_r.pend[0];
            lf = s_r.pendFlags[lch];
            // A tone qualifying on this channel in the same cycle stays pending
            s_nxt.pend[lch] = fired[lch];
            s_nxt.outFull = 1'b1;
            s_nxt.outByte = {1'b0, lch, s_r.cfg.binary ? {2'b00, flagsToCode(lf)} : lf};
        end
        if (!device_reset_n)
        begin
            s_nxt.rstCnt = (s_r.rstCnt == HOLD_LAST) ? HOLD_LAST : s_r.rstCnt + 3'd1;
            if (s_r.rstCnt == HOLD_LAST)
            begin
                s_nxt = RESET_STATE;
                s_nxt.rstCnt = HOLD_LAST;
                s_nxt.inReset = 1'b1;
            end
        end
        else
        begin
            s_nxt.rstCnt = '0;
            s_nxt.inReset = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            s_r <= RESET_STATE;
        else
            s_r <= s_nxt;
    end
    // ------------------------------------------------------------
    // Helpers: clock generator and alive toggler
    // ------------------------------------------------------------
    // internal codec clocking
    codec_clock_gen clkGen (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(!s_r.cfg.clkExternal && !s_r.inReset),
        .serialClock(sclkInt),
        .framePulse(frameInt)
    );
    alive_toggle #(
        .HALF_CYCLES(ALIVE_HALF)
    ) alive (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(!s_r.inReset),
        .aliveLevel(aliveLevel)
    );
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dataOut = s_r.outByte;
    assign dataOe = !readStrobeN && !s_r.inReset;
    assign strobeForceOe = s_r.inReset;
    assign output_latch_full_n = !s_r.outFull;
    assign input_latch_empty_flag = !writeStrobeN || s_r.inPending;
    assign alive_indicator = aliveLevel;
    assign serialClockOe = !s_r.cfg.clkExternal && !s_r.inReset;
    assign serialClockOut = sclkInt;
    assign framePulse = frameInt;
    assign serialTxFloat = s_r.inReset;
    assign cfg = s_r.cfg;
    assign detectActive = s_r.cfg.enable & (~s_r.cfg.gated | s_r.window);
    assign txCmd = s_r.tx;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic [ALIVE_W:0] aliveAge;
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            aliveAge <= '0;
        else if (s_r.inReset || $changed(aliveLevel))
            aliveAge <= '0;
        else
            aliveAge <= aliveAge + 1'b1;
    end
    AST_RESET_BYTE: assert property ($fell(s_r.inReset) |->
        !output_latch_full_n && dataOut == RESET_BYTE)
        else $error("reset byte not loaded");
    AST_RESET_CFG: assert property ($fell(s_r.inReset) |->
        cfg.clkExternal && !cfg.binary && cfg.enable == 2'b00)
        else $error("bad reset configuration");
    AST_WR_FLAG: assert property (disable iff (sys_rst || !device_reset_n)
        $rose(writeStrobeN) && !s_r.inReset |=> input_latch_empty_flag ##1
        (!input_latch_empty_flag || !writeStrobeN))
        else $error("empty flag sequence wrong");
    AST_RD_FLAG: assert property (!readStrobeN && !s_r.inReset && device_reset_n
        |=> output_latch_full_n && $stable(dataOut))
        else $error("read did not release latch");
    AST_CFG_ONE: assert property (disable iff (sys_rst || !device_reset_n)
        s_r.inPending && $stable(writeStrobeN) && s_r.inByte[7:6] == 2'b00 &&
        !s_r.inByte[ZERO_BIT] |=> cfg.clkExternal == $past(s_r.inByte[CLKSRC_BIT]) &&
        cfg.binary == $past(s_r.inByte[FORMAT_BIT]))
        else $error("config byte one not applied");
    AST_CFG_TWO: assert property (disable iff (sys_rst || !device_reset_n)
        s_r.inPending && $stable(writeStrobeN) && s_r.inByte[7:6] == 2'b01 &&
        !s_r.inByte[ZERO_BIT] |=> cfg.aLaw == $past(s_r.inByte[LAW_BIT]))
        else $error("config byte two not applied");
    AST_TX_GATE: assert property (txCmd.valid |-> cfg.enable[txCmd.channel])
        else $error("command on disabled channel");
    AST_DET_BYTE: assert property ($fell(output_latch_full_n) |-> !dataOut[CMD_BIT])
        else $error("returned byte has bit7 set");
    AST_FORCE: assert property ((!device_reset_n) [*5] |=> strobeForceOe && !dataOe &&
        !serialClockOe && serialTxFloat)
        else $error("pins not floated in reset");
    AST_ALIVE: assert property (aliveAge < (ALIVE_W + 1)'(4 * ALIVE_HALF))
        else $error("alive indicator stalled");
    COV_TX: cover property (txCmd.valid);
    COV_DET: cover property ($fell(output_latch_full_n) && !$past(s_r.inReset));
    COV_READ: cover property (!readStrobeN ##1 output_latch_full_n);
    COV_RESET: cover property ($fell(s_r.inReset));
endmodule : mf_host_port

// file: dv/mf_host_model.sv
// Host processor model driving the latch port strobes
`timescale 1ns/1ps
module mf_host_model
(
    // Clock
    input wire logic clock,
    // Latch port from the device
    input wire logic [7:0] dataOut,
    input wire logic fullN,
    input wire logic emptyFlag,
    // Latch port to the device
    output logic [7:0] dataIn,
    output logic readStrobeN,
    output logic writeStrobeN
);
    // Strobes idle high from time zero
    initial
    begin
        dataIn = 8'h00;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
    end
    // One host write; bounded waits so a stuck flag cannot hang us
    task automatic wr(input logic [7:0] b);
        for (int i = 0; i < 20 && emptyFlag !== 1'b0; i++)
            @(posedge clock);
        // strobe low, data, rising edge captures
        writeStrobeN <= 1'b0;
        dataIn <= b;
        repeat (2) @(posedge clock);
        writeStrobeN <= 1'b1;
        @(posedge clock);
        // Released bus shows the inverse, never a stale copy
        dataIn <= ~b;
        // Flag rises only after this capture edge, so look from the next one
        @(posedge clock);
        for (int i = 0; i < 20 && emptyFlag !== 1'b0; i++)
            @(posedge clock);
    endtask : wr
    // One host read; byte and full flag taken while strobe is low
    task automatic rd(output logic [7:0] b, output logic f);
        @(posedge clock);
        readStrobeN <= 1'b0;
        repeat (3) @(posedge clock);
        b = dataOut;
        f = fullN;
        readStrobeN <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : rd
endmodule : mf_host_model

// file: dv/tb_top.sv
// Self-checking testbench for the tone transceiver host port
`timescale 1ns/1ps
module tb_top
    import mf_port_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic device_reset_n = 1'b1;
    logic [1:0] rawTick = 2'b00;
    logic [1:0][5:0] rawFlags = '0;
    logic [7:0] dataIn, dataOut;
    logic readStrobeN, writeStrobeN, dataOe, strobeForceOe, output_latch_full_n;
    logic input_latch_empty_flag, alive_indicator, serialClockOut, serialClockOe;
    logic framePulse, serialTxFloat;
    logic [1:0] detectActive;
    cfg_type cfg, expCfg; // Seen and expected settings
    tx_type txCmd, txSeen; // Live and last transmit command
    int txCnt = 0, cyc = 0, error_cnt = 0, checked = 0;
    // 25 MHz clock
    always #20 clock = ~clock;
    mf_host_model host (.clock(clock), .dataOut(dataOut), .fullN(output_latch_full_n),
        .emptyFlag(input_latch_empty_flag), .dataIn(dataIn), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN));
    // Short alive period keeps the run brief
    mf_host_port #(.ALIVE_HALF(8)) dut (.clock(clock), .sys_rst(sys_rst),
        .device_reset_n(device_reset_n), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .strobeForceOe(strobeForceOe), .output_latch_full_n(output_latch_full_n),
        .input_latch_empty_flag(input_latch_empty_flag), .alive_indicator(alive_indicator),
        .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
        .framePulse(framePulse), .serialTxFloat(serialTxFloat), .cfg(cfg),
        .detectActive(detectActive), .rawTick(rawTick), .rawFlags(rawFlags), .txCmd(txCmd));
    // Catch transmit pulses and cut a hang short
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (txCmd.valid === 1'b1)
        begin
            txSeen <= txCmd;
            txCnt <= txCnt + 1;
        end
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Expected settings after one written byte
    function automatic cfg_type expOf(input cfg_type c, input logic [7:0] b);
        // odd bit0 or command leaves settings
        if (b[0] || b[7])
            return c;
        if (b[6])
            {c.aLaw, c.enable[1], c.longKp[1], c.gated[1]} = b[4:1];
        else
            {c.clkExternal, c.binary, c.enable[0], c.longKp[0], c.gated[0]} = b[5:1];
        return c;
    endfunction : expOf
    task automatic cfgw(input logic [7:0] b);
        host.wr(b);
        expCfg = expOf(expCfg, b);
        @(posedge clock);
        chk("cfg", cfg, expCfg);
    endtask : cfgw
    task automatic tx(input logic [7:0] b, input logic ok, input logic [5:0] f);
        int n;
        n = txCnt;
        host.wr(b);
        repeat (2) @(posedge clock);
        chk("txCnt", 9'(txCnt - n), 9'(ok));
        if (ok)
            chk("txCmd", {2'b00, txSeen.channel, txSeen.flags}, {2'b00, b[6], f});
    endtask : tx
    // Hold a tone past the detect time, then read the byte back
    // t ticks: one to take the flags plus the detect count, never a tick early
    task automatic tone(input int ch, input logic [5:0] f, input logic [7:0] e, input int t);
        logic [7:0] b;
        logic fl;
        rawFlags[ch] <= f;
        for (int j = 0; j < t; j++)
        begin
            if (j == t - 1)
                chk("early", 9'(output_latch_full_n), 9'd1);
            @(posedge clock) rawTick[ch] <= 1'b1;
            @(posedge clock) rawTick[ch] <= 1'b0;
        end
        rawFlags[ch] <= 6'h00;
        repeat (4) @(posedge clock);
        chk("fullLow", 9'(output_latch_full_n), 9'd0);
        host.rd(b, fl);
        chk("tone", 9'(b), 9'(e));
        chk("fullRd", 9'(fl), 9'd1);
    endtask : tone
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial
    begin
        logic [7:0] b;
        logic fl;
        int n, fr, sc;
        logic sb;
        void'($urandom(32'hc04c));
        expCfg = '0;
        expCfg.clkExternal = 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk("cfgRst", cfg, expCfg);
        host.rd(b, fl);
        chk("rstByte", 9'(b), 9'(RESET_BYTE));
        $display("test reset done");
        // Random config bytes, bit0 set on some of them
        repeat (12)
        begin
            b = 8'($urandom) & 8'h7f;
            if (b[6])
                b[5] = 1'b0;
            cfgw(b);
            chk("sclkOe", 9'(serialClockOe), 9'(!expCfg.clkExternal));
        end
        $display("test config done");
        cfgw(8'h08);
        cfgw(8'h48);
        for (int i = 0; i < 6; i++)
        begin
            b = {1'b1, 1'(i), PAIR_TABLE[1 + $urandom % 15]};
            tx(b, 1'b1, b[5:0]);
        end
        cfgw(8'h18);
        for (int k = 0; k < 16; k++)
            tx({1'b1, 1'(k), 2'b00, 4'(k)}, 1'b1, PAIR_TABLE[k]);
        tx(8'hA5, 1'b0, 6'h00);
        // Tone off on channel 2 before disabling it
        tx(8'hC0, 1'b1, 6'h00);
        cfgw(8'h40);
        tx(8'hC3, 1'b0, 6'h00);
        $display("test transmit done");
        cfgw(8'h08);
        cfgw(8'h48);
        tone(0, TONE_ST, {2'b00, TONE_ST}, 241);
        tone(1, TONE_KP, {2'b01, TONE_KP}, 241);
        cfgw(8'h18);
        tone(0, PAIR_TABLE[9], 8'h09, 241);
        // Gated: channel 1 window shut after stop tone, channel 2 open after KP
        cfgw(8'h1A);
        cfgw(8'h4A);
        chk("detAct", 9'(detectActive), 9'h002);
        // Long KP on channel 1 needs 440 ticks after the first, code 13
        cfgw(8'h1C);
        tone(0, TONE_KP, 8'h0D, 441);
        $display("test detect done");
        // Internal clocking: frame spacing and bit clocks per frame
        fr = 0;
        sc = 0;
        n = 0;
        fl = framePulse;
        sb = serialClockOut;
        for (int i = 0; i < 8000 && fr < 2; i++)
        begin
            @(posedge clock);
            if (fr == 1)
            begin
                n++;
                sc += int'(serialClockOut && !sb);
            end
            fr += int'(framePulse && !fl);
            fl = framePulse;
            sb = serialClockOut;
        end
        chk("frameCyc", 9'(n == CLK_HZ / FRAME_HZ), 9'd1);
        chk("bitClk", 9'(sc), 9'(BITS_PER_FRAME));
        $display("test clocks done");
        n = 0;
        fl = alive_indicator;
        repeat (32)
        begin
            @(posedge clock);
            n += int'(alive_indicator !== fl);
            fl = alive_indicator;
        end
        chk("alive", 9'(n >= 2), 9'd1);
        device_reset_n <= 1'b0;
        repeat (6) @(posedge clock);
        chk("float", {5'd0, strobeForceOe, serialTxFloat, dataOe, serialClockOe}, 9'h00C);
        device_reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        expCfg = '0;
        expCfg.clkExternal = 1'b1;
        chk("cfgRst2", cfg, expCfg);
        host.rd(b, fl);
        chk("rstByte2", 9'(b), 9'(RESET_BYTE));
        $display("test device reset done");
        end_of_test();
    end
endmodule : tb_top
